// >>> rtl/vps_consts.svh
`ifndef VPS_CONSTS_SVH
`define VPS_CONSTS_SVH

// Register byte offsets on the control bus
`define VPS_OFF_FEAT 5'h00
`define VPS_OFF_SEL  5'h04
`define VPS_OFF_DATA 5'h08
`define VPS_OFF_STAT 5'h0c

// Feature image: leaf 07H, sub-leaf 0, EBX
`define VPS_FEAT_BIT 5
`define VPS_FEAT_VAL (32'h0000_0001 << `VPS_FEAT_BIT)

// Selector and status field positions
`define VPS_SEL_WORD_LSB 0
`define VPS_SEL_REG_LSB  8
`define VPS_STAT_BUSY    0
`define VPS_STAT_CNT_LSB 8

// Reset values and bus answers
`define VPS_SEL_RESET 32'h0000_0000
`define VPS_RESP_OK   2'b00
`define VPS_RESP_DEC  2'b11

`endif

// >>> rtl/vps_pkg.sv
package vps_pkg;

  // Operation codes on the issue port
  typedef enum logic [3:0] {
    OP_MOVE,
    OP_DPERM,
    OP_SPERM,
    OP_QPERM,
    OP_DPPERM,
    OP_SLLD,
    OP_SLLQ,
    OP_SRLD,
    OP_SRLQ,
    OP_SRAD,
    OP_GDD,
    OP_GQD,
    OP_GDQ,
    OP_GQQ
  } vps_op_t;

  // Gather sequencer states
  typedef enum logic [1:0] {
    G_IDLE,
    G_SCAN,
    G_WAIT,
    G_DONE
  } vps_gst_t;

endpackage

// >>> rtl/vps_gif.sv
`timescale 1ns/1ns
`default_nettype none
interface vps_gif #(
  parameter int ADDR_W = 32
);
  logic              start;
  logic [255:0]      idx;
  logic [255:0]      mask;
  logic [255:0]      old;
  logic [ADDR_W-1:0] base;
  logic [1:0]        scale;
  logic              el64;
  logic              ix64;
  logic              vl256;
  logic              busy;
  logic              done;
  logic [255:0]      res;

  modport ctl (output start, idx, mask, old, base, scale, el64, ix64, vl256,
               input busy, done, res);
  modport eng (input start, idx, mask, old, base, scale, el64, ix64, vl256,
               output busy, done, res);
endinterface
`default_nettype wire

// >>> rtl/vps_alu.sv
`timescale 1ns/1ns
`default_nettype none
module vps_alu (
  // Operation and operands
  input  wire vps_pkg::vps_op_t op_i,
  input  wire logic [255:0]     a_i,
  input  wire logic [255:0]     b_i,
  input  wire logic [7:0]       imm_i,
  // Result
  output logic [255:0]          res_o
);
  logic [255:0] dperm;
  logic [255:0] qperm;
  logic [255:0] slld;
  logic [255:0] srld;
  logic [255:0] srad;
  logic [255:0] sllq;
  logic [255:0] srlq;

  // Dword lanes: index from a, data from b for permutes
  for (genvar i = 0; i < 8; i++) begin : g_d
    logic [31:0] dv;
    logic [31:0] cnt;
    logic        big;
    assign dv  = a_i[32*i +: 32];
    assign cnt = b_i[32*i +: 32];
    assign big = (cnt > 32'd31);
    assign dperm[32*i +: 32] = b_i[{a_i[32*i +: 3], 5'h00} +: 32];
    assign slld[32*i +: 32]  = big ? 32'h0000_0000 : dv << cnt[4:0];
    assign srld[32*i +: 32]  = big ? 32'h0000_0000 : dv >> cnt[4:0];
    // Saturate to sign fill rather than wrap the count
    assign srad[32*i +: 32]  = big ? {32{dv[31]}}
                                   : 32'($signed(dv) >>> cnt[4:0]);
  end

  // Qword lanes: permute picks come from the immediate
  for (genvar j = 0; j < 4; j++) begin : g_q
    logic [63:0] qv;
    logic [63:0] cnt;
    logic        big;
    assign qv  = a_i[64*j +: 64];
    assign cnt = b_i[64*j +: 64];
    assign big = (cnt > 64'd63);
    assign qperm[64*j +: 64] = b_i[{imm_i[2*j +: 2], 6'h00} +: 64];
    assign sllq[64*j +: 64]  = big ? 64'h0 : qv << cnt[5:0];
    assign srlq[64*j +: 64]  = big ? 64'h0 : qv >> cnt[5:0];
  end

  // Result select; unknown codes behave as a move
  assign res_o = (op_i == vps_pkg::OP_DPERM || op_i == vps_pkg::OP_SPERM) ? dperm :
                 (op_i == vps_pkg::OP_QPERM || op_i == vps_pkg::OP_DPPERM) ? qperm :
                 (op_i == vps_pkg::OP_SLLD) ? slld :
                 (op_i == vps_pkg::OP_SLLQ) ? sllq :
                 (op_i == vps_pkg::OP_SRLD) ? srld :
                 (op_i == vps_pkg::OP_SRLQ) ? srlq :
                 (op_i == vps_pkg::OP_SRAD) ? srad : a_i;
endmodule
`default_nettype wire

// >>> rtl/vps_gather.sv
`timescale 1ns/1ns
`default_nettype none
module vps_gather #(
  parameter int ADDR_W = 32
) (
  // Clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // Issue side
  vps_gif.eng                    g,
  // Element fetch port
  output logic                   mem_req_o,
  output logic [ADDR_W-1:0]      mem_addr_o,
  output logic                   mem_wide_o,
  input  wire logic              mem_ack_i,
  input  wire logic [63:0]       mem_rdata_i
);
  if (ADDR_W < 32 || ADDR_W > 64) begin : g_chk
    $error("vps_gather: ADDR_W must lie in 32..64");
  end

  vps_pkg::vps_gst_t st;
  logic [3:0]        e;
  logic [255:0]      idx_q;
  logic [255:0]      mask_q;
  logic [255:0]      res;
  logic [ADDR_W-1:0] base_q;
  logic [1:0]        scale_q;
  logic              el64;
  logic              ix64;
  logic              vl256;
  logic [3:0]        n;
  logic [ADDR_W-1:0] ix;
  logic [ADDR_W-1:0] addr;
  logic              mask_on;
  logic              last;

  // Lane count, element address and lane mask bit
  assign n = vl256 ? ((el64 | ix64) ? 4'h4 : 4'h8) : ((el64 | ix64) ? 4'h2 : 4'h4);
  assign last = (e == n);
  assign ix = ix64 ? idx_q[{e[1:0], 6'h00} +: ADDR_W]
                   : ADDR_W'($signed(idx_q[{e[2:0], 5'h00} +: 32]));
  assign addr = base_q + ADDR_W'(ix << scale_q);
  assign mask_on = el64 ? mask_q[{e[1:0], 6'h3f}] : mask_q[{e[2:0], 5'h1f}];
  assign g.busy = (st != vps_pkg::G_IDLE);
  assign g.done = (st == vps_pkg::G_DONE);
  assign g.res  = res;

  // Operands are latched so the issue side may move on
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idx_q   <= '0;
      mask_q  <= '0;
      base_q  <= '0;
      scale_q <= 2'h0;
      el64    <= 1'b0;
      ix64    <= 1'b0;
      vl256   <= 1'b0;
    end else if (ce_i && g.start && st == vps_pkg::G_IDLE) begin
      idx_q   <= g.idx;
      mask_q  <= g.mask;
      base_q  <= g.base;
      scale_q <= g.scale;
      el64    <= g.el64;
      ix64    <= g.ix64;
      vl256   <= g.vl256;
    end
  end

  // One fetch in flight; lanes with mask clear are skipped
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st         <= vps_pkg::G_IDLE;
      e          <= 4'h0;
      res        <= '0;
      mem_req_o  <= 1'b0;
      mem_addr_o <= '0;
      mem_wide_o <= 1'b0;
    end else if (ce_i) begin
      case (st)
        vps_pkg::G_IDLE: if (g.start) begin
          res        <= g.old;
          e          <= 4'h0;
          mem_wide_o <= g.el64;
          st         <= vps_pkg::G_SCAN;
        end
        vps_pkg::G_SCAN: if (last) begin
          st <= vps_pkg::G_DONE;
        end else if (mask_on) begin
          mem_req_o  <= 1'b1;
          mem_addr_o <= addr;
          st         <= vps_pkg::G_WAIT;
        end else begin
          e <= e + 4'h1;
        end
        vps_pkg::G_WAIT: if (mem_ack_i) begin
          mem_req_o <= 1'b0;
          if (el64) res[{e[1:0], 6'h00} +: 64] <= mem_rdata_i;
          else res[{e[2:0], 5'h00} +: 32] <= mem_rdata_i[31:0];
          e  <= e + 4'h1;
          st <= vps_pkg::G_SCAN;
        end
        vps_pkg::G_DONE: st <= vps_pkg::G_IDLE;
        default: st <= vps_pkg::G_IDLE;
      endcase
    end
  end

  default clocking gcb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  req_mask_on_a: assert property (mem_req_o |-> mask_on)
    else $error("fetch issued for a masked-off lane");
  skip_hold_a: assert property ((st == vps_pkg::G_SCAN && !last && !mask_on)
    |=> res == $past(res))
    else $error("masked-off lane altered the merge value");
  merge_dword_a: assert property ((mem_req_o && mem_ack_i && ce_i && !el64)
    |=> res[{$past(e[2:0]), 5'h00} +: 32] == $past(mem_rdata_i[31:0]))
    else $error("fetched dword not merged into its lane");
  addr_d_a: assert property ((mem_req_o && !ix64) |-> mem_addr_o == base_q
    + ADDR_W'(ADDR_W'($signed(idx_q[{e[2:0], 5'h00} +: 32])) << scale_q))
    else $error("dword index address wrong");
  gather_done_c: cover property (st == vps_pkg::G_DONE);
endmodule
`default_nettype wire

// >>> rtl/vps_top.sv
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "vps_consts.svh"
`default_nettype none
module vps_top #(
  parameter int NREG   = 16,
  parameter int ADDR_W = 32
) (
  // Clock, reset, enable
  input  wire logic                    CLK_I,
  input  wire logic                    RST_I,
  input  wire logic                    CE_I,
  // Instruction issue
  input  wire logic                    INS_VALID_I,
  output logic                         INS_READY_O,
  input  wire logic [3:0]              INS_OP_I,
  input  wire logic                    INS_PREFIX_I,
  input  wire logic                    INS_VL256_I,
  input  wire logic [$clog2(NREG)-1:0] INS_DST_I,
  input  wire logic [$clog2(NREG)-1:0] INS_SRC1_I,
  input  wire logic [$clog2(NREG)-1:0] INS_SRC2_I,
  input  wire logic [7:0]              INS_IMM_I,
  input  wire logic [1:0]              INS_SCALE_I,
  input  wire logic [ADDR_W-1:0]       INS_BASE_I,
  output logic                         INS_DONE_O,
  // Gather memory port
  output logic                         MEM_REQ_O,
  output logic [ADDR_W-1:0]            MEM_ADDR_O,
  output logic                         MEM_WIDE_O,
  input  wire logic                    MEM_ACK_I,
  input  wire logic [63:0]             MEM_RDATA_I,
  // AXI4-Lite write
  input  wire logic                    AWVALID_I,
  output logic                         AWREADY_O,
  input  wire logic [4:0]              AWADDR_I,
  input  wire logic                    WVALID_I,
  output logic                         WREADY_O,
  input  wire logic [31:0]             WDATA_I,
  input  wire logic [3:0]              WSTRB_I,
  output logic                         BVALID_O,
  input  wire logic                    BREADY_I,
  output logic [1:0]                   BRESP_O,
  // AXI4-Lite read
  input  wire logic                    ARVALID_I,
  output logic                         ARREADY_O,
  input  wire logic [4:0]              ARADDR_I,
  output logic                         RVALID_O,
  input  wire logic                    RREADY_I,
  output logic [31:0]                  RDATA_O,
  output logic [1:0]                   RRESP_O
);
  localparam int RW = $clog2(NREG);

  if (NREG < 2 || NREG > 256) begin : g_chk
    $error("vps_top: NREG must lie in 2..256");
  end

  // Register file: one store per register, both views share it
  logic [255:0]      rf [NREG];
  logic [255:0]      s1;
  logic [255:0]      s2;
  logic [255:0]      alu_res;
  vps_pkg::vps_op_t  op;
  logic              is_g;
  logic              ins_go;

  // Writeback path
  logic              wb_en;
  logic [RW-1:0]     wb_dst;
  logic              wb_pre;
  logic              wb_vl;
  logic [255:0]      wb_res;
  logic [255:0]      wb_old;
  logic [255:0]      wb_data;
  logic [RW-1:0]     gdst;
  logic              gpre;
  logic              gvl;
  logic [7:0]        ret_cnt;

  // Control bus state
  logic              aw_have;
  logic [4:0]        aw_addr;
  logic              w_have;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_go;
  logic              wr_bad;
  logic              wr_data_sel;
  logic              wr_sel_sel;
  logic [2:0]        sel_word;
  logic [RW-1:0]     sel_reg;
  logic [31:0]       sel_val;
  logic [31:0]       sel_word_val;
  logic              ar_go;
  logic              rd_bad;
  logic [31:0]       rd_val;

  vps_gif #(.ADDR_W(ADDR_W)) g ();

  // Byte-lane merge for strobed writes
  function automatic logic [31:0] bmerge(input logic [31:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
    for (int b = 0; b < 4; b++) begin
      bmerge[8*b +: 8] = s[b] ? d[8*b +: 8] : o[8*b +: 8];
    end
  endfunction

  // Operand read and decode
  assign op     = vps_pkg::vps_op_t'(INS_OP_I);
  assign s1     = rf[INS_SRC1_I];
  assign s2     = rf[INS_SRC2_I];
  assign is_g   = op inside {vps_pkg::OP_GDD, vps_pkg::OP_GQD,
                             vps_pkg::OP_GDQ, vps_pkg::OP_GQQ};
  // Issue stalls for the whole gather, one op at a time
  assign INS_READY_O = CE_I && !g.busy;
  assign ins_go      = INS_VALID_I && INS_READY_O;

  vps_alu u_alu (
    .op_i  (op),
    .a_i   (s1),
    .b_i   (s2),
    .imm_i (INS_IMM_I),
    .res_o (alu_res)
  );

  // Gather launch: index vector in src1, mask in src2
  assign g.start = ins_go && is_g;
  assign g.idx   = s1;
  assign g.mask  = s2;
  assign g.old   = rf[INS_DST_I];
  assign g.base  = INS_BASE_I;
  assign g.scale = INS_SCALE_I;
  assign g.el64  = (op == vps_pkg::OP_GDQ) || (op == vps_pkg::OP_GQQ);
  assign g.ix64  = (op == vps_pkg::OP_GQD) || (op == vps_pkg::OP_GQQ);
  assign g.vl256 = INS_VL256_I;

  vps_gather #(.ADDR_W(ADDR_W)) u_gat (
    .clk_i       (CLK_I),
    .rst_i       (RST_I),
    .ce_i        (CE_I),
    .g           (g),
    .mem_req_o   (MEM_REQ_O),
    .mem_addr_o  (MEM_ADDR_O),
    .mem_wide_o  (MEM_WIDE_O),
    .mem_ack_i   (MEM_ACK_I),
    .mem_rdata_i (MEM_RDATA_I)
  );

  // Gather destination and encoding held across the fetches
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      gdst <= '0;
      gpre <= 1'b0;
      gvl  <= 1'b0;
    end else if (g.start) begin
      gdst <= INS_DST_I;
      gpre <= INS_PREFIX_I;
      gvl  <= INS_VL256_I;
    end
  end

  // Writeback select and upper-half handling
  assign wb_en   = CE_I && ((ins_go && !is_g) || g.done);
  assign wb_dst  = g.done ? gdst : INS_DST_I;
  assign wb_pre  = g.done ? gpre : INS_PREFIX_I;
  assign wb_vl   = g.done ? gvl : INS_VL256_I;
  assign wb_res  = g.done ? g.res : alu_res;
  assign wb_old  = rf[wb_dst];
  assign wb_data = !wb_pre ? {wb_old[255:128], wb_res[127:0]} :
                   !wb_vl  ? {128'h0, wb_res[127:0]} :
                   wb_res;

  // Datapath wins the port; a bus restore waits until wb_en drops
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int k = 0; k < NREG; k++) rf[k] <= '0;
    end else if (wb_en) begin
      rf[wb_dst] <= wb_data;
    end else if (wr_go && wr_data_sel) begin
      rf[sel_reg][{sel_word, 5'h00} +: 32] <= bmerge(sel_word_val, w_data, w_strb);
    end
  end

  // Completion pulse and retired-op counter
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      INS_DONE_O <= 1'b0;
      ret_cnt    <= 8'h00;
    end else if (CE_I) begin
      INS_DONE_O <= wb_en;
      if (wb_en) ret_cnt <= ret_cnt + 8'h01;
    end
  end

  // Write decode; read-only offsets accept and ignore
  assign AWREADY_O   = CE_I && !aw_have;
  assign WREADY_O    = CE_I && !w_have;
  assign wr_go       = CE_I && aw_have && w_have && !BVALID_O && !wb_en;
  assign wr_bad      = (aw_addr[1:0] != 2'b00) || (aw_addr > `VPS_OFF_STAT);
  assign wr_data_sel = (aw_addr == `VPS_OFF_DATA);
  assign wr_sel_sel  = (aw_addr == `VPS_OFF_SEL);
  assign sel_val     = (32'(sel_reg) << `VPS_SEL_REG_LSB)
                     | (32'(sel_word) << `VPS_SEL_WORD_LSB);
  assign sel_word_val = rf[sel_reg][{sel_word, 5'h00} +: 32];

  // Address and data captured independently, any order
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      aw_have <= 1'b0;
      aw_addr <= 5'h00;
      w_have  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else if (CE_I) begin
      if (AWVALID_I && AWREADY_O) begin
        aw_have <= 1'b1;
        aw_addr <= AWADDR_I;
      end else if (wr_go) begin
        aw_have <= 1'b0;
      end
      if (WVALID_I && WREADY_O) begin
        w_have <= 1'b1;
        w_data <= WDATA_I;
        w_strb <= WSTRB_I;
      end else if (wr_go) begin
        w_have <= 1'b0;
      end
    end
  end

  // Response and the selector register
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      BVALID_O <= 1'b0;
      BRESP_O  <= `VPS_RESP_OK;
      sel_word <= 3'(`VPS_SEL_RESET >> `VPS_SEL_WORD_LSB);
      sel_reg  <= RW'(`VPS_SEL_RESET >> `VPS_SEL_REG_LSB);
    end else if (CE_I) begin
      if (wr_go) begin
        BVALID_O <= 1'b1;
        BRESP_O  <= wr_bad ? `VPS_RESP_DEC : `VPS_RESP_OK;
      end else if (BREADY_I) begin
        BVALID_O <= 1'b0;
      end
      if (wr_go && wr_sel_sel && w_strb[0]) sel_word <= w_data[`VPS_SEL_WORD_LSB +: 3];
      if (wr_go && wr_sel_sel && w_strb[1]) sel_reg <= w_data[`VPS_SEL_REG_LSB +: RW];
    end
  end

  // Read decode; reserved bits read zero
  assign ARREADY_O = CE_I && !RVALID_O;
  assign ar_go     = ARVALID_I && ARREADY_O;
  assign rd_bad    = (ARADDR_I[1:0] != 2'b00) || (ARADDR_I > `VPS_OFF_STAT);
  assign rd_val    = (ARADDR_I == `VPS_OFF_FEAT) ? `VPS_FEAT_VAL :
                     (ARADDR_I == `VPS_OFF_SEL)  ? sel_val :
                     (ARADDR_I == `VPS_OFF_DATA) ? sel_word_val :
                     (ARADDR_I == `VPS_OFF_STAT) ?
                       ((32'(ret_cnt) << `VPS_STAT_CNT_LSB)
                       | (32'(g.busy) << `VPS_STAT_BUSY)) :
                     32'h0000_0000;

  // Read answer one cycle after the address is taken
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RVALID_O <= 1'b0;
      RDATA_O  <= 32'h0000_0000;
      RRESP_O  <= `VPS_RESP_OK;
    end else if (CE_I) begin
      if (ar_go) begin
        RVALID_O <= 1'b1;
        RDATA_O  <= rd_val;
        RRESP_O  <= rd_bad ? `VPS_RESP_DEC : `VPS_RESP_OK;
      end else if (RREADY_I) begin
        RVALID_O <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  feat_bit_a: assert property (ar_go && ARADDR_I == `VPS_OFF_FEAT
    |=> RVALID_O && RDATA_O[`VPS_FEAT_BIT])
    else $error("feature bit not reported");
  alias_low_a: assert property (wb_en
    |=> rf[$past(wb_dst)][127:0] == $past(wb_res[127:0]))
    else $error("low half not written through");
  keep_upper_a: assert property (wb_en && !wb_pre
    |=> rf[$past(wb_dst)][255:128] == $past(wb_old[255:128]))
    else $error("unprefixed write changed upper half");
  zero_upper_a: assert property (wb_en && wb_pre && !wb_vl
    |=> rf[$past(wb_dst)][255:128] == 128'h0)
    else $error("narrow prefixed write left upper half");
  full_write_a: assert property (wb_en && wb_pre && wb_vl
    |=> rf[$past(wb_dst)] == $past(wb_res))
    else $error("wide write lost upper half");
  save_read_a: assert property (ar_go && ARADDR_I == `VPS_OFF_DATA
    |=> RDATA_O == $past(sel_word_val))
    else $error("save window read wrong word");
  dperm_pick_a: assert property (ins_go && op == vps_pkg::OP_DPERM
    |-> alu_res[31:0] == s2[{s1[2:0], 5'h00} +: 32])
    else $error("dword permute picked wrong element");
  qperm_pick_a: assert property (ins_go && op == vps_pkg::OP_QPERM
    |-> alu_res[255:192] == s2[{INS_IMM_I[7:6], 6'h00} +: 64])
    else $error("qword permute ignored immediate");
  sra_fill_a: assert property (ins_go && op == vps_pkg::OP_SRAD && s2[95:64] > 32'd31
    |-> alu_res[95:64] == {32{s1[95]}})
    else $error("large arithmetic count not sign filled");
  sll_shift_a: assert property (ins_go && op == vps_pkg::OP_SLLQ && s2[63:0] < 64'd64
    |-> alu_res[63:0] == s1[63:0] << s2[5:0])
    else $error("qword left shift wrong");
  srl_shift_a: assert property (ins_go && op == vps_pkg::OP_SRLD && s2[31:0] < 32'd32
    |-> alu_res[31:0] == s1[31:0] >> s2[4:0])
    else $error("dword logical right shift wrong");

  dperm_run_c: cover property (ins_go && op == vps_pkg::OP_DPERM);
  legacy_wb_c: cover property (wb_en && !wb_pre);
  gather_wb_c: cover property (wb_en && g.done);
  bad_read_c: cover property (RVALID_O && RREADY_I && RRESP_O == `VPS_RESP_DEC);
endmodule
`default_nettype wire

// >>> tb/vps_mem.sv
`timescale 1ns/1ns
`default_nettype none
module vps_mem (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Element fetch port
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  input  wire logic        wide_i,
  output logic             ack_o,
  output logic [63:0]      rdata_o
);
  // One wait state; idle data toggles so a stale sample never matches
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o   <= 1'b0;
      rdata_o <= 64'h0;
    end else if (req_i && !ack_o) begin
      ack_o   <= 1'b1;
      rdata_o <= {wide_i ? ~addr_i : 32'h0, addr_i};
    end else begin
      ack_o   <= 1'b0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "vps_consts.svh"
module tb;
  // Bench signals
  logic         clk, rst, iv, pre, vl, awv, wv, br, arv, rr;
  logic         ir, dn, mrq, mwd, mak, awr, wrdy, bv, arr, rv;
  logic [3:0]   op, ws, dst, s1, s2;
  logic [7:0]   imm;
  logic [1:0]   sc, bre, rre, rsp;
  logic [31:0]  base, mad, wd, rdat, ga;
  logic [4:0]   awa, ara;
  logic [63:0]  mrd;
  logic [255:0] va, vb, vp, got, ge;
  int           errors, num_checks, cyc, nreq;

  vps_top vps_top_i (.CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .INS_VALID_I(iv),
    .INS_READY_O(ir), .INS_OP_I(op), .INS_PREFIX_I(pre), .INS_VL256_I(vl), .INS_DST_I(dst),
    .INS_SRC1_I(s1), .INS_SRC2_I(s2), .INS_IMM_I(imm), .INS_SCALE_I(sc), .INS_BASE_I(base),
    .INS_DONE_O(dn), .MEM_REQ_O(mrq), .MEM_ADDR_O(mad), .MEM_WIDE_O(mwd), .MEM_ACK_I(mak),
    .MEM_RDATA_I(mrd), .AWVALID_I(awv), .AWREADY_O(awr), .AWADDR_I(awa), .WVALID_I(wv),
    .WREADY_O(wrdy), .WDATA_I(wd), .WSTRB_I(ws), .BVALID_O(bv), .BREADY_I(br),
    .BRESP_O(bre), .ARVALID_I(arv), .ARREADY_O(arr), .ARADDR_I(ara), .RVALID_O(rv),
    .RREADY_I(rr), .RDATA_O(rdat), .RRESP_O(rre));
  vps_mem vps_mem_i (.clk_i(clk), .rst_i(rst), .req_i(mrq), .addr_i(mad), .wide_i(mwd),
    .ack_o(mak), .rdata_o(mrd));

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cycle ceiling and count of finished fetches
  always @(posedge clk) begin
    cyc++;
    if (mrq && mak) nreq++;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [255:0] g, input logic [255:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Address and data offered together, each dropped once taken; bready stays up
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    awa <= a;
    wd  <= d;
    ws  <= 4'hf;
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (!bv);
    chk(bre, `VPS_RESP_OK);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    d = rdat;
    r = rre;
  endtask

  // Whole vector registers move one word at a time through the selector
  task automatic setreg(input logic [3:0] n, input logic [255:0] v);
    for (int w = 0; w < 8; w++) begin
      wr(`VPS_OFF_SEL, {20'h0, n, 5'h0, w[2:0]});
      wr(`VPS_OFF_DATA, v[32*w+:32]);
    end
  endtask

  task automatic getreg(input logic [3:0] n, output logic [255:0] v);
    logic [31:0] d;
    logic [1:0]  r;
    for (int w = 0; w < 8; w++) begin
      wr(`VPS_OFF_SEL, {20'h0, n, 5'h0, w[2:0]});
      rd(`VPS_OFF_DATA, d, r);
      v[32*w+:32] = d;
    end
  endtask

  task automatic ins(input logic [3:0] o, input logic p, l, input logic [3:0] d, b);
    op  <= o;
    pre <= p;
    vl  <= l;
    dst <= d;
    s2  <= b;
    iv  <= 1'b1;
    do @(posedge clk); while (!ir);
    iv <= 1'b0;
    do @(posedge clk); while (!dn);
  endtask

  // Reference result; oversized counts fall out of the shift operators
  function automatic logic [255:0] expv(input logic [3:0] o, input logic [255:0] a, b);
    logic [255:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      case (o)
        4'h0: r[32*i+:32] = a[32*i+:32];
        4'h1, 4'h2: r[32*i+:32] = b[32*a[32*i+:3]+:32];
        4'h3, 4'h4: if (i < 4) r[64*i+:64] = b[64*imm[2*i+:2]+:64];
        4'h5: r[32*i+:32] = a[32*i+:32] << b[32*i+:32];
        4'h6: if (i < 4) r[64*i+:64] = a[64*i+:64] << b[64*i+:64];
        4'h7: r[32*i+:32] = a[32*i+:32] >> b[32*i+:32];
        4'h8: if (i < 4) r[64*i+:64] = a[64*i+:64] >> b[64*i+:64];
        default: r[32*i+:32] = $signed(a[32*i+:32]) >>> b[32*i+:32];
      endcase
    end
    return r;
  endfunction

  // Merge target refilled each time; lane results are fetch addresses, with the inverted address on top for qwords
  task automatic t_gat(input logic [3:0] o, input logic [255:0] e, input int n);
    setreg(7, ~vb);
    nreq = 0;
    ins(o, 1'b1, 1'b1, 4'h7, 4'h6);
    getreg(7, got);
    chk(got, e);
    chk(nreq, n);
  endtask

  initial begin
    {iv, pre, vl, awv, wv, br, arv, rr, op, ws, dst, s2, imm, awa, ara, wd} = '0;
    s1   = 4'h1;
    sc   = 2'h2;
    base = 32'h1000;
    rst  = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Feature image and an unmapped address
    rd(`VPS_OFF_FEAT, ga, rsp);
    chk(ga, `VPS_FEAT_VAL);
    chk(rsp, `VPS_RESP_OK);
    rd(5'h10, ga, rsp);
    chk(rsp, `VPS_RESP_DEC);
    // Every permute and shift at full width
    va = 256'h80000004_f0000006_00ff0002_a5a5a505_7fffff01_c0000007_12345603_fedcba00;
    vb = 256'h00000028_0000001f_00000000_00000040_00000000_0000003f_00000000_00000003;
    setreg(1, va);
    setreg(2, vb);
    setreg(3, ~va);
    imm <= 8'h9c;
    for (int o = 0; o < 10; o++) begin
      vp = (o < 5) ? ~va : vb;
      ins(o[3:0], 1'b1, 1'b1, 4'h4, (o < 5) ? 4'h3 : 4'h2);
      getreg(4, got);
      chk(got, expv(o[3:0], va, vp));
    end
    // Narrow writes: unprefixed keeps the upper half, prefixed clears it
    setreg(5, ~vb);
    ins(4'h5, 1'b0, 1'b0, 4'h5, 4'h9);
    getreg(5, got);
    chk(got, {~vb[255:128], va[127:0]});
    ins(4'h5, 1'b1, 1'b0, 4'h5, 4'h9);
    getreg(5, got);
    chk(got, {128'h0, va[127:0]});
    // Gathers with two lanes and one lane enabled
    setreg(6, 256'h80000000 << 160 | 256'h80000000);
    ge = ~vb;
    ge[31:0] = base + (va[31:0] << 2);
    ge[191:160] = base + (va[191:160] << 2);
    t_gat(4'ha, ge, 2);
    ge = ~vb;
    ga = base + (va[95:64] << 2);
    ge[191:128] = {~ga, ga};
    t_gat(4'hc, ge, 1);
    report_and_stop();
  end
endmodule
`default_nettype wire
